// ---- verilog/inline_crypt_pkg.sv ----
// constants and types of the inline crypt engine
package inline_crypt_pkg;

   // bus and key widths
   localparam int ADDR_W   = 32;
   localparam int DATA_W   = 32;
   localparam int BE_W     = 4;
   localparam int KEY_W    = 128;
   localparam int HALF_W   = 64;
   localparam int PRIV_W   = 2;
   localparam int ENCL_W   = 32;
   localparam int RID_W    = 16;
   localparam int COLOR_W  = 8;

   // control register selectors
   localparam logic [2:0] CSR_KEY0 = 3'h0;
   localparam logic [2:0] CSR_KEY3 = 3'h3;
   localparam logic [2:0] CSR_END  = 3'h4;

   // reset values
   localparam logic [DATA_W-1:0] KEY_RESET = 32'h00000000;
   localparam logic [DATA_W-1:0] END_RESET = 32'h00000000;

   // byte enable of a whole word
   localparam logic [BE_W-1:0] BE_FULL = 4'hF;

   // 4-bit substitution and its inverse, entry i at bits 4*i
   localparam logic [63:0] SBOX     = 64'h21748FE3DA09B65C;
   localparam logic [63:0] INV_SBOX = 64'hA970364BD21C8FE5;

   // keystream cipher shape
   localparam int          CIPHER_ROUNDS = 6;
   localparam logic [63:0] ROUND_CONST   = 64'hC0AC29B7C97C50DD;

   // depth of the fetch context queue
   localparam int CTX_DEPTH = 16;

   // request half of a bus port
   typedef struct packed {
      logic              req;
      logic              we;
      logic [BE_W-1:0]   be;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } obi_req_t;

   // answer half of a bus port
   typedef struct packed {
      logic              gnt;
      logic              rvalid;
      logic              err;
      logic [DATA_W-1:0] rdata;
   } obi_rsp_t;

   // what a fetch response needs from its address phase
   typedef struct packed {
      logic             in_region;
      logic [KEY_W-1:0] key;
   } fetch_ctx_t;

   typedef enum logic [2:0] {
      D_IDLE     = 3'b000,
      D_RD_WAIT  = 3'b001,
      D_WR_WAIT  = 3'b010,
      D_RMW_RD   = 3'b011,
      D_RMW_WR   = 3'b100
   } data_state_t;

endpackage : inline_crypt_pkg

// ---- verilog/inline_crypt_engine.sv ----
// inline crypt engine: fetch decryptor, data crypt unit, context fifo
// Summary of operation
// - writing any key or region-end register raises the pipeline flush
// - four key registers, a region-end register and its read-only alias
// - fetch tweak is address, privilege level and enclave tweak
// - every fetch from the encrypted region is decrypted; no encrypt path
// - instruction port writes are never issued by the core
// - key derived in fetch address phase, latched with the address
// - region spans base parameter up to region-end register
// - valid fetch response inside region gets unscrambled read data
// - all other instruction port signals pass unchanged, except req and gnt, held low while the context queue is full
// - fetch adds no cycles; key ready, unscrambling combinational
// - decryption works on 32-bit blocks with a keyed unscrambler
// - keystream from two 64-bit ciphers, one pipeline stage, tweak split
// - 128-bit key gives four round keys around first and last rounds
// - inverse round: key add, inverse mix, inverse shift, inverse sbox, key
// - data tweak: address, privilege, return id, colour, enclave tweak
// - region writes encrypted to memory, region reads decrypted to core
// - full-word store key available in its address phase
// - subword store reads, decrypts, merges, re-encrypts, then stores
// - no further memory request while a region store is handled
// - encryption uses forward rounds with round keys reversed
`timescale 1ns/100ps
`default_nettype none

module ctx_fifo #(
   parameter int WIDTH = 129,
   parameter int DEPTH = inline_crypt_pkg::CTX_DEPTH
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   // pointers wrap, so depth is a power of two
   localparam int PTR_W = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0]            wr_ptr;
      logic [PTR_W-1:0]            rd_ptr;
      logic [PTR_W:0]              count;
   } fifo_state_t;
   fifo_state_t st;
   fifo_state_t next_st;
   logic        push;
   logic        pop;
   always_comb begin
      in_ready  = (st.count != (PTR_W+1)'(DEPTH));
      out_valid = (st.count != '0);
      out_data  = st.mem[st.rd_ptr];
      push      = in_valid & in_ready;
      pop       = out_valid & out_ready;
      next_st   = st;
      if (push) begin
         next_st.mem[st.wr_ptr] = in_data;
         next_st.wr_ptr         = st.wr_ptr + 1'b1;
      end
      if (pop) begin
         next_st.rd_ptr = st.rd_ptr + 1'b1;
      end
      next_st.count = st.count + {{PTR_W{1'b0}}, push}
                               - {{PTR_W{1'b0}}, pop};
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule : ctx_fifo
module inline_crypt_engine #(
   parameter logic [31:0] region_base_param = 32'h00000000,
   parameter int          CTX_DEPTH         = inline_crypt_pkg::CTX_DEPTH
) (
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     rst,
   // control registers
   input  wire logic                     csr_we,
   input  wire logic [2:0]               csr_sel,
   input  wire logic [31:0]              csr_wdata,
   output logic [31:0]                   csr_rdata,
   output logic [31:0]                   region_end_user,
   output logic                          pipeline_flush,
   // tweak sources
   input  wire logic [1:0]               fetch_priv,
   input  wire logic [1:0]               data_priv,
   input  wire logic [31:0]              enclave_tweak,
   input  wire logic [15:0]              return_id,
   input  wire logic [7:0]               ptr_colour,
   // instruction port, core side
   input  wire inline_crypt_pkg::obi_req_t core_instr_req,
   output inline_crypt_pkg::obi_rsp_t    core_instr_rsp,
   // instruction port, memory side
   output inline_crypt_pkg::obi_req_t    mem_instr_req,
   input  wire inline_crypt_pkg::obi_rsp_t mem_instr_rsp,
   // data port, core side
   input  wire inline_crypt_pkg::obi_req_t core_data_req,
   output inline_crypt_pkg::obi_rsp_t    core_data_rsp,
   // data port, memory side
   output inline_crypt_pkg::obi_req_t    mem_data_req,
   input  wire inline_crypt_pkg::obi_rsp_t mem_data_rsp
);
   localparam int CTX_W    = inline_crypt_pkg::KEY_W + 1;
   localparam int FPAD_W   = inline_crypt_pkg::KEY_W - inline_crypt_pkg::ADDR_W
                           - inline_crypt_pkg::PRIV_W - inline_crypt_pkg::ENCL_W;
   localparam int DPAD_W   = FPAD_W - inline_crypt_pkg::RID_W
                           - inline_crypt_pkg::COLOR_W;
   typedef struct packed {
      logic [3:0][31:0]              key_words;
      logic [31:0]                   region_end;
      logic [31:0]                   csr_rdata;
      inline_crypt_pkg::data_state_t dstate;
      logic [127:0]                  dkey;
      logic [31:0]                   daddr;
      logic [31:0]                   dwdata;
      logic [3:0]                    dbe;
      logic [31:0]                   dword;
      logic [3:0]                    pass_cnt;
   } engine_state_t;
   engine_state_t             st;
   engine_state_t             next_st;
   logic [127:0]              inline_key;
   logic [127:0]              fetch_key;
   logic [127:0]              data_key;
   logic                      fetch_in_region;
   logic                      data_in_region;
   logic                      ctx_push;
   logic                      ctx_ready;
   logic                      ctx_valid;
   inline_crypt_pkg::fetch_ctx_t ctx_head;
   inline_crypt_pkg::fetch_ctx_t ctx_new;
   logic [31:0]               merged;
   // keystream cipher
   function automatic logic [63:0] block_cipher(input logic [63:0]  pt,
                                                input logic [127:0] key);
      logic [63:0] s;
      s = pt ^ key[63:0];
      for (int r = 0; r < inline_crypt_pkg::CIPHER_ROUNDS; r++) begin
         for (int i = 0; i < 16; i++) begin
            s[4*i +: 4] = inline_crypt_pkg::SBOX[{s[4*i +: 4], 2'b00} +: 4];
         end
         s = {s[50:0], s[63:51]} ^ s ^ inline_crypt_pkg::ROUND_CONST
             ^ (r[0] ? key[127:64] : key[63:0]);
      end
      return s;
   endfunction : block_cipher
   // tweak halves into two ciphers
   function automatic logic [127:0] derive_key(input logic [127:0] tweak,
                                               input logic [127:0] key);
      return {block_cipher(tweak[127:64], key),
              block_cipher(tweak[63:0], key)};
   endfunction : derive_key
   function automatic logic [31:0] sub_word(input logic [31:0] x,
                                            input logic [63:0] tbl);
      logic [31:0] y;
      y = '0;
      for (int i = 0; i < 8; i++) begin
         y[4*i +: 4] = tbl[{x[4*i +: 4], 2'b00} +: 4];
      end
      return y;
   endfunction : sub_word
   // two rows of four nibbles, low half row zero
   function automatic logic [31:0] fwd_round(input logic [31:0] x,
                                             input logic [31:0] ka,
                                             input logic [31:0] kb);
      logic [31:0] s;
      s = sub_word(x ^ ka, inline_crypt_pkg::SBOX);
      s = {s[27:16], s[31:28], s[15:0]};
      s = {s[15:0], s[15:0] ^ s[31:16]};
      return s ^ kb;
   endfunction : fwd_round
   function automatic logic [31:0] inv_round(input logic [31:0] x,
                                             input logic [31:0] ka,
                                             input logic [31:0] kb);
      logic [31:0] s;
      s = x ^ ka;
      s = {s[15:0] ^ s[31:16], s[31:16]};
      s = {s[19:16], s[31:20], s[15:0]};
      s = sub_word(s, inline_crypt_pkg::INV_SBOX);
      return s ^ kb;
   endfunction : inv_round
   function automatic logic [31:0] unscramble(input logic [31:0]  c,
                                              input logic [127:0] k);
      // round keys wrap the first and last inverse rounds
      return inv_round(inv_round(c, k[31:0], k[63:32]),
                       k[95:64], k[127:96]);
   endfunction : unscramble
   function automatic logic [31:0] scramble(input logic [31:0]  p,
                                            input logic [127:0] k);
      // forward rounds, round keys taken in reverse
      return fwd_round(fwd_round(p, k[127:96], k[95:64]),
                       k[63:32], k[31:0]);
   endfunction : scramble
   function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  be);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            m[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return m;
   endfunction : merge_bytes
   // end is exclusive: a zero end leaves the region empty
   function automatic logic region_hit(input logic [31:0] addr,
                                       input logic [31:0] rend);
      return (addr >= region_base_param) && (addr < rend);
   endfunction : region_hit
   assign inline_key = st.key_words;
   // fetch tweak and key in address phase
   always_comb begin
      fetch_key = derive_key({core_instr_req.addr, fetch_priv,
                              enclave_tweak, {FPAD_W{1'b0}}},
                             inline_key);
      fetch_in_region   = region_hit(core_instr_req.addr, st.region_end);
      ctx_new.in_region = fetch_in_region;
      ctx_new.key       = fetch_key;
      // queue entry is the keystream pipeline stage
      ctx_push = core_instr_req.req & mem_instr_rsp.gnt;
   end
   // one context per outstanding fetch
   ctx_fifo #(
      .WIDTH (CTX_W),
      .DEPTH (CTX_DEPTH)
   ) u_ctx_fifo (
      .mclk      (mclk),
      .rst       (rst),
      .in_valid  (ctx_push),
      .in_ready  (ctx_ready),
      .in_data   (ctx_new),
      .out_valid (ctx_valid),
      .out_ready (mem_instr_rsp.rvalid),
      .out_data  (ctx_head)
   );
   // fetch path passes all but read data, and req and gnt, gated by queue space
   always_comb begin
      mem_instr_req     = core_instr_req;
      mem_instr_req.req = core_instr_req.req & ctx_ready;
      core_instr_rsp     = mem_instr_rsp;
      core_instr_rsp.gnt = mem_instr_rsp.gnt & ctx_ready;
      // no register on this path, so fetch latency is untouched
      if (mem_instr_rsp.rvalid && ctx_valid && ctx_head.in_region) begin
         core_instr_rsp.rdata = unscramble(mem_instr_rsp.rdata,
                                           ctx_head.key);
      end
   end
   // data crypt unit and control registers
   always_comb begin
      data_key = derive_key({core_data_req.addr, data_priv, return_id,
                             ptr_colour, enclave_tweak,
                             {DPAD_W{1'b0}}}, inline_key);
      data_in_region = region_hit(core_data_req.addr, st.region_end);
      merged  = merge_bytes(unscramble(mem_data_rsp.rdata, st.dkey),
                            st.dwdata, st.dbe);
      next_st = st;
      mem_data_req  = '0;
      core_data_rsp = '0;
      pipeline_flush = 1'b0;
      // keys are write-only, read as zero
      if (csr_we) begin
         if (csr_sel <= inline_crypt_pkg::CSR_KEY3) begin
            next_st.key_words[csr_sel[1:0]] = csr_wdata;
         end else if (csr_sel == inline_crypt_pkg::CSR_END) begin
            next_st.region_end = csr_wdata;
         end
         pipeline_flush = (csr_sel <= inline_crypt_pkg::CSR_END);
      end
      next_st.csr_rdata = (csr_sel == inline_crypt_pkg::CSR_END)
                        ? st.region_end : 32'h00000000;
      unique case (st.dstate)
         inline_crypt_pkg::D_IDLE: begin
            // answers here are pass-through ones
            core_data_rsp.rvalid = mem_data_rsp.rvalid;
            core_data_rsp.err    = mem_data_rsp.err;
            core_data_rsp.rdata  = mem_data_rsp.rdata;
            if (core_data_req.req && !data_in_region) begin
               if (st.pass_cnt != 4'hF) begin
                  mem_data_req      = core_data_req;
                  core_data_rsp.gnt = mem_data_rsp.gnt;
               end
            end else if (core_data_req.req && st.pass_cnt == 4'h0) begin
               // region access waits for answers to drain
               mem_data_req      = core_data_req;
               core_data_rsp.gnt = mem_data_rsp.gnt;
               if (!core_data_req.we) begin
                  if (mem_data_rsp.gnt) begin
                     next_st.dkey   = data_key;
                     next_st.dstate = inline_crypt_pkg::D_RD_WAIT;
                  end
               end else if (core_data_req.be == inline_crypt_pkg::BE_FULL) begin
                  // key used in the same address phase
                  mem_data_req.wdata = scramble(core_data_req.wdata,
                                                data_key);
                  if (mem_data_rsp.gnt) begin
                     next_st.dstate = inline_crypt_pkg::D_WR_WAIT;
                  end
               end else begin
                  // subword store reads the whole word
                  mem_data_req.we   = 1'b0;
                  mem_data_req.be   = inline_crypt_pkg::BE_FULL;
                  mem_data_req.addr = {core_data_req.addr[31:2], 2'b00};
                  if (mem_data_rsp.gnt) begin
                     next_st.dkey   = data_key;
                     next_st.daddr  = {core_data_req.addr[31:2], 2'b00};
                     next_st.dwdata = core_data_req.wdata;
                     next_st.dbe    = core_data_req.be;
                     next_st.dstate = inline_crypt_pkg::D_RMW_RD;
                  end
               end
            end
            next_st.pass_cnt = st.pass_cnt
               + {3'h0, mem_data_req.req & mem_data_rsp.gnt & !data_in_region}
               - {3'h0, mem_data_rsp.rvalid};
         end
         inline_crypt_pkg::D_RD_WAIT: begin
            core_data_rsp.rvalid = mem_data_rsp.rvalid;
            core_data_rsp.err    = mem_data_rsp.err;
            core_data_rsp.rdata  = unscramble(mem_data_rsp.rdata,
                                              st.dkey);
            if (mem_data_rsp.rvalid) begin
               next_st.dstate = inline_crypt_pkg::D_IDLE;
            end
         end
         inline_crypt_pkg::D_RMW_RD: begin
            // read answer swallowed; bus error aborts store
            if (mem_data_rsp.rvalid && mem_data_rsp.err) begin
               core_data_rsp.rvalid = 1'b1;
               core_data_rsp.err    = 1'b1;
               next_st.dstate       = inline_crypt_pkg::D_IDLE;
            end else if (mem_data_rsp.rvalid) begin
               next_st.dword  = scramble(merged, st.dkey);
               next_st.dstate = inline_crypt_pkg::D_RMW_WR;
            end
         end
         inline_crypt_pkg::D_RMW_WR: begin
            mem_data_req.req   = 1'b1;
            mem_data_req.we    = 1'b1;
            mem_data_req.be    = inline_crypt_pkg::BE_FULL;
            mem_data_req.addr  = st.daddr;
            mem_data_req.wdata = st.dword;
            if (mem_data_rsp.gnt) begin
               next_st.dstate = inline_crypt_pkg::D_WR_WAIT;
            end
         end
         inline_crypt_pkg::D_WR_WAIT: begin
            // core ungranted until store completes
            core_data_rsp.rvalid = mem_data_rsp.rvalid;
            core_data_rsp.err    = mem_data_rsp.err;
            core_data_rsp.rdata  = mem_data_rsp.rdata;
            if (mem_data_rsp.rvalid) begin
               next_st.dstate = inline_crypt_pkg::D_IDLE;
            end
         end
         default: begin
            next_st.dstate = inline_crypt_pkg::D_IDLE;
         end
      endcase
   end
   assign csr_rdata       = st.csr_rdata;
   assign region_end_user = st.region_end;
   always_ff @(posedge mclk) begin
      if (rst) begin
         st            <= '0;
         st.key_words  <= {4{inline_crypt_pkg::KEY_RESET}};
         st.region_end <= inline_crypt_pkg::END_RESET;
         st.dstate     <= inline_crypt_pkg::D_IDLE;
      end else begin
         st <= next_st;
      end
   end

endmodule : inline_crypt_engine

`default_nettype wire

// ---- tb/crypt_checker.sv ----
// port assertions of the inline crypt engine
`timescale 1ns/100ps
`default_nettype none
module crypt_checker #(
   parameter logic [31:0] region_base_param = 32'h00000000
) (
   // clock, reset and control
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        csr_we,
   input wire logic [2:0]  csr_sel,
   input wire logic [31:0] csr_wdata,
   input wire logic [31:0] csr_rdata,
   input wire logic [31:0] region_end_user,
   input wire logic        pipeline_flush,
   // bus ports
   input wire inline_crypt_pkg::obi_req_t core_instr_req,
   input wire inline_crypt_pkg::obi_rsp_t core_instr_rsp,
   input wire inline_crypt_pkg::obi_req_t mem_instr_req,
   input wire inline_crypt_pkg::obi_rsp_t mem_instr_rsp,
   input wire inline_crypt_pkg::obi_req_t core_data_req,
   input wire inline_crypt_pkg::obi_rsp_t core_data_rsp,
   input wire inline_crypt_pkg::obi_req_t mem_data_req,
   input wire inline_crypt_pkg::obi_rsp_t mem_data_rsp
);
   wire logic in_d = core_data_req.addr >= region_base_param
                     && core_data_req.addr < region_end_user;
   wire logic in_m = mem_data_req.addr >= region_base_param
                     && mem_data_req.addr < region_end_user;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // subword store accepted into the region
   sequence rmw_start;
      core_data_req.req && core_data_req.we && in_d
      && core_data_req.be != inline_crypt_pkg::BE_FULL
      && core_data_rsp.gnt;
   endsequence
   sequence wr_taken;
      mem_data_req.req && mem_data_req.we && mem_data_rsp.gnt && in_m;
   endsequence
   AST_FLUSH: assert property (pipeline_flush == (csr_we && csr_sel <= 3'h4))
      else $error("bad flush");
   AST_ALIAS: assert property (csr_we && csr_sel == 3'h4 |=> region_end_user == $past(csr_wdata))
      else $error("alias stale");
   AST_END_HOLD: assert property (!(csr_we && csr_sel == 3'h4) |=> $stable(region_end_user))
      else $error("end changed");
   AST_READ: assert property ($past(csr_sel) <= 3'h4 && !$past(csr_we) |-> csr_rdata == ($past(csr_sel) == 3'h4 ? region_end_user : 32'h0))
      else $error("bad read");
   AST_RESET_END: assert property ($fell(rst) |-> region_end_user == 32'h0)
      else $error("end not reset");
   AST_F_PASS: assert property (core_instr_rsp.rvalid == mem_instr_rsp.rvalid && core_instr_rsp.err == mem_instr_rsp.err)
      else $error("fetch answer altered");
   AST_F_REQ: assert property (mem_instr_req.addr == core_instr_req.addr && mem_instr_req.be == core_instr_req.be)
      else $error("fetch request altered");
   AST_F_GNT: assert property (core_instr_rsp.gnt |-> mem_instr_rsp.gnt && mem_instr_req.req)
      else $error("fetch gnt wrong");
   AST_D_RVALID: assert property (core_data_rsp.rvalid |-> mem_data_rsp.rvalid)
      else $error("stray rvalid");
   AST_D_PASS: assert property (core_data_rsp.gnt && !in_d |-> mem_data_req == core_data_req)
      else $error("outside access altered");
   AST_RMW_READ: assert property (rmw_start |-> !mem_data_req.we && mem_data_req.be == 4'hF && mem_data_req.addr == {core_data_req.addr[31:2], 2'b00})
      else $error("rmw read wrong");
   AST_RMW_WRITE: assert property (rmw_start |-> ##[2:40] mem_data_req.req && mem_data_req.we && mem_data_req.be == 4'hF)
      else $error("rmw write missing");
   AST_WR_HOLD: assert property (wr_taken |=> !mem_data_req.req || mem_data_rsp.rvalid)
      else $error("request during store");
endmodule : crypt_checker

bind inline_crypt_engine crypt_checker #(
   .region_base_param(region_base_param)
) u_chk (.mclk(mclk), .rst(rst), .csr_we(csr_we), .csr_sel(csr_sel),
   .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
   .region_end_user(region_end_user), .pipeline_flush(pipeline_flush),
   .core_instr_req(core_instr_req), .core_instr_rsp(core_instr_rsp),
   .mem_instr_req(mem_instr_req), .mem_instr_rsp(mem_instr_rsp),
   .core_data_req(core_data_req), .core_data_rsp(core_data_rsp),
   .mem_data_req(mem_data_req), .mem_data_rsp(mem_data_rsp));
`default_nettype wire

// ---- tb/mem_model.sv ----
// memory model of one bus port
`timescale 1ns/100ps
`default_nettype none
module mem_model (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // grant every other cycle
   input  wire logic slow,
   // bus port
   input  wire inline_crypt_pkg::obi_req_t req,
   output inline_crypt_pkg::obi_rsp_t      rsp
);
   logic [31:0] mem [0:127];
   logic [31:0] rd;
   logic        pend;
   logic        tick = 1'b0;
   wire  [6:0]  idx = req.addr[8:2];
   always_comb begin
      rsp.gnt    = req.req && (!slow || tick);
      rsp.rvalid = pend;
      rsp.err    = 1'b0;
      // idle data is the inverse
      rsp.rdata  = pend ? rd : ~rd;
   end
   always_ff @(posedge mclk) begin
      tick <= !tick;
      pend <= rsp.gnt && !rst;
      if (rst) begin
         rd <= 32'h00000000;
         for (int i = 0; i < 128; i++) mem[i] <= 32'hC3A50000 | i;
      end else if (rsp.gnt && !req.we) begin
         rd <= mem[idx];
      end else if (rsp.gnt) begin
         for (int b = 0; b < 4; b++)
            if (req.be[b]) mem[idx][8*b+:8] <= req.wdata[8*b+:8];
      end
   end
endmodule : mem_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench of the inline crypt engine
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic mclk = 1'b0, rst = 1'b1, csr_we = 1'b0, slow = 1'b0;
   logic [2:0]  csr_sel = 3'h0;
   logic [1:0]  data_priv = 2'h0;
   logic [31:0] csr_wdata = 32'h0, csr_rdata, region_end_user, r;
   logic        pipeline_flush;
   inline_crypt_pkg::obi_req_t ci_req = '0, cd_req = '0, mi_req, md_req;
   inline_crypt_pkg::obi_rsp_t ci_rsp, cd_rsp, mi_rsp, md_rsp;
   int error_cnt = 0, checks = 0, cyc = 0;
   inline_crypt_engine #(.region_base_param(32'h0)) uut (.mclk(mclk),
      .rst(rst), .csr_we(csr_we), .csr_sel(csr_sel), .csr_wdata(csr_wdata),
      .csr_rdata(csr_rdata), .region_end_user(region_end_user),
      .pipeline_flush(pipeline_flush), .fetch_priv(2'h3),
      .data_priv(data_priv), .enclave_tweak(32'h0), .return_id(16'h0),
      .ptr_colour(8'h0), .core_instr_req(ci_req), .core_instr_rsp(ci_rsp),
      .mem_instr_req(mi_req), .mem_instr_rsp(mi_rsp),
      .core_data_req(cd_req), .core_data_rsp(cd_rsp),
      .mem_data_req(md_req), .mem_data_rsp(md_rsp));
   mem_model u_imem (.mclk(mclk), .rst(rst), .slow(slow), .req(mi_req), .rsp(mi_rsp));
   mem_model u_dmem (.mclk(mclk), .rst(rst), .slow(slow), .req(md_req), .rsp(md_rsp));
   always #5 mclk = ~mclk;
   task automatic end_sim;
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   always @(posedge mclk) begin
      cyc++;
      // run needs about a hundred cycles
      if (cyc == 20000) begin
         error_cnt++;
         end_sim();
      end
   end
   // ne: values must differ
   task automatic chk(input logic [31:0] got, exp, input logic ne);
      checks++;
      if (ne ? got === exp : got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic csr_write(input logic [2:0] s, input logic [31:0] v);
      @(posedge mclk);
      csr_we <= 1'b1;
      csr_sel <= s;
      csr_wdata <= v;
      #1 chk(pipeline_flush, s <= 3'h4, 1'b0);
      @(posedge mclk);
      csr_we <= 1'b0;
      #1;
   endtask : csr_write
   // d: data port, else fetch port
   task automatic xfer(input logic d, we, input logic [3:0] be,
         input logic [31:0] a, wd, output logic [31:0] rd);
      @(posedge mclk);
      if (d) cd_req <= '{1'b1, we, be, a, wd};
      else ci_req <= '{1'b1, 1'b0, be, a, wd};
      do @(posedge mclk); while ((d ? cd_rsp.gnt : ci_rsp.gnt) !== 1'b1);
      cd_req.req <= 1'b0;
      ci_req.req <= 1'b0;
      do @(posedge mclk); while ((d ? cd_rsp.rvalid : ci_rsp.rvalid) !== 1'b1);
      rd = d ? cd_rsp.rdata : ci_rsp.rdata;
   endtask : xfer
   task automatic t_csr;
      chk(region_end_user, 32'h0, 1'b0);
      for (int k = 0; k < 4; k++) csr_write(k[2:0], 32'h9E3779B9 * (k + 1));
      csr_write(3'h4, 32'h100);
      chk(region_end_user, 32'h100, 1'b0);
      csr_write(3'h5, 32'h0);
      chk(region_end_user, 32'h100, 1'b0);
      @(posedge mclk) csr_sel <= 3'h4;
      @(posedge mclk) #1 chk(csr_rdata, 32'h100, 1'b0);
      @(posedge mclk) csr_sel <= 3'h1;
      @(posedge mclk) #1 chk(csr_rdata, 32'h0, 1'b0);
   endtask : t_csr
   task automatic t_fetch;
      logic [31:0] fa [4] = '{32'h8, 32'hFC, 32'h100, 32'h104};
      foreach (fa[i]) begin
         xfer(1'b0, 1'b0, 4'hF, fa[i], 32'h0, r);
         chk(r, 32'hC3A50000 | fa[i][8:2], fa[i] < 32'h100);
      end
   endtask : t_fetch
   task automatic t_plain;
      xfer(1'b1, 1'b1, 4'hF, 32'h180, 32'hDEADBEEF, r);
      chk(u_dmem.mem[7'h60], 32'hDEADBEEF, 1'b0);
      xfer(1'b1, 1'b1, 4'h2, 32'h180, 32'h0000AA00, r);
      xfer(1'b1, 1'b0, 4'hF, 32'h180, 32'h0, r);
      chk(r, 32'hDEADAAEF, 1'b0);
   endtask : t_plain
   // store, merge, tweak and key change
   task automatic t_region(input logic [31:0] a);
      xfer(1'b1, 1'b1, 4'hF, a, 32'h12345678, r);
      chk(u_dmem.mem[a[8:2]], 32'h12345678, 1'b1);
      xfer(1'b1, 1'b0, 4'hF, a, 32'h0, r);
      chk(r, 32'h12345678, 1'b0);
      xfer(1'b1, 1'b1, 4'h4, a, 32'h00AB0000, r);
      xfer(1'b1, 1'b0, 4'hF, a, 32'h0, r);
      chk(r, 32'h12AB5678, 1'b0);
      @(posedge mclk) data_priv <= 2'h1;
      xfer(1'b1, 1'b0, 4'hF, a, 32'h0, r);
      chk(r, 32'h12AB5678, 1'b1);
      @(posedge mclk) data_priv <= 2'h0;
      csr_write(3'h2, 32'h0BADF00D);
      xfer(1'b1, 1'b0, 4'hF, a, 32'h0, r);
      chk(r, 32'h12AB5678, 1'b1);
      csr_write(3'h2, 32'h9E3779B9 * 3);
   endtask : t_region
   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk) #1;
      t_csr();
      t_fetch();
      t_plain();
      t_region(32'h10);
      @(posedge mclk) slow <= 1'b1;
      t_region(32'h20);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
